// *** verilog/event_link_tx.sv ***
// Purpose: transmitting end of the one-wire system event link
// Assumes: 100 MHz clock; link steps once per two clocks
// Notes:   event line is open-drain style: driven low or released high
`timescale 1ns/100ps
`include "event_link_defs.svh"
// Overview of operation
// - decoded events latch and trigger a frame
// - counter runs 1 to 19 driving states
// - active frame never interrupted, no event lost
// - at count 19 idle unless work pending
// - shifter serialises event word onto line
// - data phase moves level one to two
// - turnaround clears level two, rechecks level one
// - link clock is system clock halved
// - nine low start bits, counts 1 to 9
// - eight data bits, one means occurred
// - fixed event order stop-grant first, video last
// - turnaround ends frame, restart or idle
module event_link_tx
  import event_link_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire event_word_s eventIn,
  input  wire logic        eventValid,
  output logic             eventReady,
  output logic             linkBusy,
  output logic             eventLinkOut,
  output logic             eventLinkOe
);
  link_state_e                state_r;
  link_state_e                state_nxt;
  logic [`EVL_CNT_W-1:0]      count_r;
  logic [`EVL_CNT_W-1:0]      count_nxt;
  logic [`EVL_DIV_W-1:0]      div_r;
  event_word_s                pend_r;
  event_word_s                pend_nxt;
  event_word_s                shift_r;
  event_word_s                shift_nxt;
  logic                       lineLow_r;
  logic                       lineLow_nxt;

  event_word_s                bufWord;
  logic                       bufValid;
  logic                       bufReady;
  wire  [`EVL_EVENT_W-1:0]    mergeBits;
  wire  [`EVL_EVENT_W-1:0]    shiftBits;

  // the machine owns the line from the first start bit to count 19
  function automatic logic frameActive(input link_state_e s);
    return (s != LINK_IDLE);
  endfunction : frameActive

  // a one is sent by releasing the line, a zero by pulling it low
  function automatic logic dataLow(input logic bitVal);
    return !bitVal;
  endfunction : dataLow

  // buffer absorbs words while level one is busy being merged
  event_skid_buffer u_buf (
    .clock    (clock),
    .resetn   (resetn),
    .inWord   (eventIn),
    .inValid  (eventValid),
    .inReady  (eventReady),
    .outWord  (bufWord),
    .outValid (bufValid),
    .outReady (bufReady)
  );

  wire linkTick   = (div_r == `EVL_DIV_LAST);
  wire pendAny    = (pend_r != `EVL_EVENT_ZERO);
  wire atLast     = (count_r == `EVL_CNT_LAST);
  wire atStartEnd = (count_r == `EVL_START_LAST);
  wire atDataEnd  = (count_r == `EVL_DATA_LAST);
  wire inStart    = (state_r == LINK_START);
  wire inData     = (state_r == LINK_DATA);
  wire inTurn     = (state_r == LINK_TURN);
  wire enterData  = linkTick && inStart && atStartEnd;
  wire dataStep   = linkTick && inData;
  wire turnStep   = linkTick && inTurn;
  wire startBegin = (state_nxt == LINK_START) && !inStart;
  // merging stalls only on the tick that hands level one to level two
  assign bufReady = !enterData;
  wire takeWord   = bufValid && bufReady;

  // level one keeps accumulating; events are ored, never dropped
  genvar gi;
  generate
    for (gi = 0; gi < `EVL_EVENT_W; gi++) begin : g_bit
      assign mergeBits[gi] = pend_r[gi] | (takeWord & bufWord[gi]);
      if (gi == `EVL_EVENT_W - 1) begin : g_top
        // the last bit out is followed by a zero, never a stale event
        assign shiftBits[gi] = 1'b0;
      end else begin : g_low
        assign shiftBits[gi] = shift_r[gi + 1];
      end
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LINK_IDLE: begin
        if (pendAny) state_nxt = LINK_START;
      end
      LINK_START: begin
        if (atStartEnd) state_nxt = LINK_DATA;
      end
      LINK_DATA: begin
        if (atDataEnd) state_nxt = LINK_TURN;
      end
      LINK_TURN: begin
        // events that came in meanwhile go out in the very next frame
        if (atLast) state_nxt = pendAny ? LINK_START : LINK_IDLE;
      end
      default: state_nxt = LINK_IDLE;
    endcase
  end

  // a fresh frame restarts the count, idle parks it below the first count
  always_comb begin
    count_nxt = count_r + 5'h01;
    if (startBegin) begin
      count_nxt = `EVL_CNT_FIRST;
    end else if (!frameActive(state_nxt)) begin
      count_nxt = `EVL_CNT_FIRST - 5'h01;
    end
  end

  // low in start bits, data bit shifted lsb first, high otherwise
  always_comb begin
    lineLow_nxt = 1'b0;
    case (state_nxt)
      LINK_START: begin
        lineLow_nxt = 1'b1;
      end
      LINK_DATA: begin
        // bit 0 of the shifter is on the line now, bit 1 goes next
        if (enterData) lineLow_nxt = dataLow(pend_r[0]);
        else lineLow_nxt = dataLow(shift_r[1]);
      end
      default: begin
        lineLow_nxt = 1'b0;
      end
    endcase
  end

  always_comb begin
    pend_nxt  = mergeBits;
    shift_nxt = shift_r;
    if (enterData) begin
      shift_nxt = pend_r;
      pend_nxt  = `EVL_EVENT_ZERO;
    end else if (dataStep) begin
      shift_nxt = shiftBits;
    end else if (turnStep) begin
      shift_nxt = `EVL_EVENT_ZERO;
    end
  end

  // divider phase restarts with reset; the far end locks to the line
  always_ff @(posedge clock) begin
    if (!resetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= LINK_IDLE;
    end else if (linkTick) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (linkTick) begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lineLow_r <= 1'b0;
    end else if (linkTick) begin
      lineLow_r <= lineLow_nxt;
    end
  end

  // level one keeps taking words while level two is shifted out
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pend_r <= `EVL_EVENT_ZERO;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      shift_r <= `EVL_EVENT_ZERO;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // the pin only ever pulls low; the pull-up supplies the high level
  assign eventLinkOut = 1'b0;
  assign eventLinkOe  = !lineLow_r;
  assign linkBusy     = frameActive(state_r);
endmodule : event_link_tx

// *** shared/event_link_defs.svh ***
// Purpose: timing and field constants for the event serial link
// Assumes: 100 MHz system clock, link clock is system clock divided by two
// Notes:   included by the package and by the design modules
`ifndef EVENT_LINK_DEFS_SVH
`define EVENT_LINK_DEFS_SVH
`define EVL_EVENT_W      8
`define EVL_CNT_W        5
`define EVL_CNT_FIRST    5'h01
`define EVL_START_LAST   5'h09
`define EVL_DATA_FIRST   5'h0a
`define EVL_DATA_LAST    5'h11
`define EVL_TURN_FIRST   5'h12
`define EVL_CNT_LAST     5'h13
`define EVL_DIV_W        1
`define EVL_DIV_LAST     1'h1
`define EVL_BUF_DEPTH    2
`define EVL_EVENT_ZERO   8'h00
`endif

// *** shared/event_link_pkg.sv ***
// Purpose: types shared by the event link transmitter and its buffer
// Assumes: constants come from event_link_defs.svh
// Notes:   bit 0 of the event word is the first bit on the line
`include "event_link_defs.svh"
package event_link_pkg;
  typedef struct packed {
    logic videoAccessEvent;
    logic ioTrapTwoEvent;
    logic ioTrapOneEvent;
    logic busMasterRequestEvent;
    logic diskAccessEvent;
    logic serialPortAccess;
    logic parallelPortAccess;
    logic stopGrantEvent;
  } event_word_s;
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_START,
    LINK_DATA,
    LINK_TURN
  } link_state_e;
endpackage : event_link_pkg

// *** verilog/event_skid_buffer.sv ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   inReady is low only when both entries hold words
`timescale 1ns/100ps
`include "event_link_defs.svh"
module event_skid_buffer
  import event_link_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire event_word_s inWord,
  input  wire logic        inValid,
  output logic             inReady,
  output event_word_s      outWord,
  output logic             outValid,
  input  wire logic        outReady
);
  event_word_s mem_r [`EVL_BUF_DEPTH];
  logic        wrPtr_r;
  logic        rdPtr_r;
  logic [1:0]  fill_r;
  wire         doPush = inValid && inReady;
  wire         doPop  = outValid && outReady;

  assign inReady  = (fill_r != 2'h2);
  assign outValid = (fill_r != 2'h0);
  assign outWord  = mem_r[rdPtr_r];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      fill_r  <= 2'h0;
    end else begin
      if (doPush) wrPtr_r <= ~wrPtr_r;
      if (doPop) rdPtr_r <= ~rdPtr_r;
      fill_r <= fill_r + {1'b0, doPush} - {1'b0, doPop};
    end
  end

  always_ff @(posedge clock) begin
    if (doPush) mem_r[wrPtr_r] <= inWord;
  end
endmodule : event_skid_buffer

// *** verif/event_link_chk.sv ***
// Purpose: pin timing checks on the event link transmitter
// Assumes: one clock, synchronous active-low reset
// Notes:   pos is the clock within a 38-clock frame, 0 when idle
`timescale 1ns/100ps
module event_link_chk
  import event_link_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire event_word_s eventIn,
  input wire logic        eventValid,
  input wire logic        eventReady,
  input wire logic        linkBusy,
  input wire logic        eventLinkOut,
  input wire logic        eventLinkOe
);
  logic [5:0] pos_r;
  wire  [5:0] pos = (pos_r == 6'h00 || pos_r == 6'h26) ?
                    {5'h00, !eventLinkOe} : pos_r + 6'h01;
  always_ff @(posedge clock) pos_r <= resetn ? pos : 6'h00;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  reset_idle_a: assert property ($rose(resetn) |-> eventLinkOe
    && !linkBusy && eventReady) else $error("not idle");
  start_low_a: assert property (pos >= 6'h01 && pos <= 6'h12
    |-> !eventLinkOe) else $error("start bit");
  bit_hold_a: assert property (pos >= 6'h13 && pos <= 6'h22
    && !pos[0] |-> $stable(eventLinkOe)) else $error("bit width");
  turn_high_a: assert property (pos >= 6'h23 |-> eventLinkOe)
    else $error("turnaround");
  busy_frame_a: assert property (pos != 6'h00 |-> linkBusy)
    else $error("busy");
  idle_high_a: assert property (!linkBusy |-> eventLinkOe)
    else $error("idle level");
  drive_low_a: assert property (!eventLinkOe |-> !eventLinkOut)
    else $error("drive");
  start_soon_a: assert property (eventValid && eventReady && |eventIn
    && !linkBusy |-> ##[1:8] !eventLinkOe) else $error("no start");
  frame_end_a: assert property (pos == 6'h26 |=>
    !eventLinkOe || !linkBusy) else $error("frame end");
endmodule : event_link_chk

// *** verif/event_link_rx_model.sv ***
// Purpose: receiving end of the event link
// Assumes: line already resolved with its pull-up
// Notes:   samples a bit in its second clock, so it trails by half a bit
`timescale 1ns/100ps
module event_link_rx_model
  import event_link_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   resetn,
  input  wire logic   line,
  output event_word_s rxWord,
  output logic        rxValid
);
  logic [5:0] cnt_r;
  logic [6:0] bits_r;
  always_ff @(posedge clock) begin
    rxValid <= 1'b0;
    if (!resetn) cnt_r <= 6'h00;
    else if (cnt_r == 6'h00) cnt_r <= {5'h00, !line};
    else if (cnt_r < 6'h12 && line) cnt_r <= 6'h00;
    else begin
      cnt_r <= (cnt_r == 6'h25) ? 6'h00 : cnt_r + 6'h01;
      if (cnt_r >= 6'h13 && cnt_r < 6'h21 && cnt_r[0]) begin
        bits_r[cnt_r[3:1] - 3'h1] <= line;
      end
      if (cnt_r == 6'h21) begin
        rxWord <= {line, bits_r};
        rxValid <= 1'b1;
      end
    end
  end
endmodule : event_link_rx_model

// *** verif/event_serial_link_tb_top.sv ***
// Purpose: self-checking bench for the event link transmitter
// Assumes: receiver model frames the line; line has a pull-up
// Notes:   events sent after a frame's start bits merge into the next one
`timescale 1ns/100ps
module event_serial_link_tb_top
  import event_link_pkg::*;
;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        eventValid = 1'b0;
  event_word_s eventIn = 8'h00;
  event_word_s rxWord;
  logic        eventReady, linkBusy, eventLinkOut, eventLinkOe, rxValid;
  wire         line = eventLinkOe ? 1'b1 : eventLinkOut;
  int          fail_count = 0, n_compared = 0, seed = 32'h4beb, cyc = 0;
  logic [7:0]  exp[$];
  logic [7:0]  w;
  always #5 clock = ~clock;
  event_link_tx DUT(.clock(clock), .resetn(resetn), .eventIn(eventIn),
    .eventValid(eventValid), .eventReady(eventReady), .linkBusy(linkBusy),
    .eventLinkOut(eventLinkOut), .eventLinkOe(eventLinkOe));
  event_link_rx_model u_rx(.clock(clock), .resetn(resetn), .line(line),
    .rxWord(rxWord), .rxValid(rxValid));
  task chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task send(input logic [7:0] v);
    eventIn = v;
    eventValid = 1'b1;
    while (eventReady !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
  endtask : send
  task drain;
    eventValid = 1'b0;
    wait (exp.size() == 0);
    repeat (10) @(posedge clock);
    #1;
    chk({7'h00, linkBusy}, 8'h00);
    chk({7'h00, line}, 8'h01);
  endtask : drain
  always @(negedge clock) begin
    if (rxValid === 1'b1)
      chk(rxWord, exp.size() ? exp.pop_front() : 8'h00);
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 12; i++) begin
      w = (i < 8) ? 8'h01 << i : 8'($random(seed)) | 8'h20;
      exp.push_back(w);
      send(w);
      drain();
    end
    $display("test single done");
    exp.push_back(8'h5a);
    send(8'h5a);
    eventValid = 1'b0;
    wait (linkBusy === 1'b1);
    repeat (25) @(posedge clock);
    #1;
    w = 8'($random(seed)) | 8'h10;
    exp.push_back(w | 8'h03);
    send(w);
    send(8'h03);
    drain();
    $display("test merge done");
    test_done();
  end
endmodule : event_serial_link_tb_top
bind event_link_tx event_link_chk u_chk(.clock(clock), .resetn(resetn),
  .eventIn(eventIn), .eventValid(eventValid), .eventReady(eventReady),
  .linkBusy(linkBusy), .eventLinkOut(eventLinkOut),
  .eventLinkOe(eventLinkOe));
